// >>> src/sacc_defs.svh
/*
 Timing counts, encodings and reset values for the converter control block.
 Assumes inclusion by bare name from src/.
*/
`ifndef SACC_DEFS_SVH
`define SACC_DEFS_SVH
`define SACC_RES_BITS        10
`define SACC_CONV_PERIODS    12
`define SACC_CHAN_RESET      6'h00
`define SACC_PREF_RESET      2'h0
`define SACC_CLKSEL_RESET    3'h0
`define SACC_CLKSEL_RC_LOW   2'h3
`define SACC_SYS_CLK_MHZ     125
`define SACC_INSTR_NS        32
`define SACC_INSTR_CYCLES    ((`SACC_INSTR_NS * `SACC_SYS_CLK_MHZ + 999) / 1000)
`define SACC_RC_HALF_DIV     8'h20
`endif

// >>> src/sacc_pkg.sv
/*
 Types for the converter control block.
 Assumes nothing beyond the defs header.
*/
package sacc_pkg;
   typedef enum logic [2:0] {
      SACC_IDLE,
      SACC_RC_WAIT,
      SACC_SAMPLE,
      SACC_BITS,
      SACC_FINISH
   } sacc_state_t;
endpackage

// >>> src/sacc_sync.sv
/*
 Three-stage synchroniser; a change counts once stages two and three agree.
 Assumes the input is asynchronous to clk_sys.
*/
`timescale 1ns/1ps
module sacc_sync (
   input  wire logic clk_sys,
   input  wire logic arst_n,
   input  wire logic async_in,
   output logic      sync_out
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s1       <= 1'b0;
         s2       <= 1'b0;
         s3       <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         s1 <= async_in;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            sync_out <= s3;
         end
      end
   end
endmodule // sacc_sync

// >>> src/sacc_clkgen.sv
/*
 Conversion clock tick generator: system prescaler or local RC stand-in.
 Assumes clk_sys is the system clock; ticks are one-cycle pulses.
*/
`timescale 1ns/1ps
`include "sacc_defs.svh"
module sacc_clkgen
   import sacc_pkg::*;
#(
   parameter logic [7:0] RC_DIV = `SACC_RC_HALF_DIV
) (
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic       run,
   input  wire logic [2:0] conv_clock_select,
   output logic            tick
);
   logic [7:0] cnt;
   logic [7:0] limit;
   wire        use_rc = (conv_clock_select[1:0] == `SACC_CLKSEL_RC_LOW);

   // Divider ratio from the select code; x11 uses a fixed divide.
   always_comb begin
      case (conv_clock_select)
         3'h0:    limit = 8'h01;
         3'h4:    limit = 8'h03;
         3'h1:    limit = 8'h07;
         3'h5:    limit = 8'h0f;
         3'h2:    limit = 8'h1f;
         3'h6:    limit = 8'h3f;
         default: limit = RC_DIV;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt  <= 8'h00;
         tick <= 1'b0;
      end else if (!run) begin
         cnt  <= 8'h00;
         tick <= 1'b0;
      end else if (cnt >= limit) begin
         cnt  <= 8'h00;
         tick <= 1'b1;
      end else begin
         cnt  <= cnt + 8'h01;
         tick <= 1'b0;
      end
   end

   // Prescaled ticks come at most every other clk_sys cycle; RC ticks use their own ratio.
   tick_ratio_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (run && !use_rc && conv_clock_select == 3'h0 && $past(run) && tick) |=> !tick)
      else $error("prescaler tick too fast");
endmodule // sacc_clkgen

// >>> src/sacc_top.sv
/*
 Successive-approximation converter control: channel and reference select,
 conversion clock, start/done handshake, done flag, sleep and wake, result
 justification. Assumes the analog mux, sample-hold and comparator outside;
 comp_hi_async is the comparator verdict for the present trial code.
*/
`timescale 1ns/1ps
`include "sacc_defs.svh"
module sacc_top
   import sacc_pkg::*;
#(
   parameter int RES_BITS = `SACC_RES_BITS
) (
   input  wire logic       clk_sys,
   input  wire logic       arst_n,
   input  wire logic       module_on,
   input  wire logic       go_write,
   input  wire logic       flag_clear,
   input  wire logic [5:0] channel_select,
   input  wire logic [1:0] positive_ref_select,
   input  wire logic       negative_ref_select,
   input  wire logic [2:0] conv_clock_select,
   input  wire logic       result_justify,
   input  wire logic       conversion_irq_enable,
   input  wire logic       peripheral_irq_enable,
   input  wire logic       global_irq_enable,
   input  wire logic       sleep_mode,
   input  wire logic       comp_hi_async,
   output logic [5:0]      mux_channel,
   output logic [1:0]      pref_sel,
   output logic            nref_sel,
   output logic            analog_power,
   output logic            sample_hold,
   output logic [9:0]      trial_code,
   output logic            go_done,
   output logic            conversion_done_flag,
   output logic [7:0]      result_high,
   output logic [7:0]      result_low,
   output logic            wake_up,
   output logic            vector_isr
);
   sacc_state_t state;
   sacc_state_t next_state;
   logic [3:0]  period_cnt;
   logic [3:0]  bit_idx;
   logic [3:0]  rc_wait;
   logic [9:0]  sar;
   logic        module_on_q;
   logic        powered_down;
   logic        comp_hi;
   logic        tick;

   wire use_rc    = (conv_clock_select[1:0] == `SACC_CLKSEL_RC_LOW);
   wire run_ok    = module_on && !powered_down && !(sleep_mode && !use_rc);
   wire start_ok  = go_write && module_on_q && run_ok && state == SACC_IDLE;
   wire converting = (state != SACC_IDLE);
   wire abort     = converting && !run_ok;
   wire last_bit  = (state == SACC_BITS) && tick && bit_idx == 4'h0;
   wire finish    = (state == SACC_FINISH) && tick;
   wire wake_ok   = conversion_irq_enable && peripheral_irq_enable;
   wire tick_run  = converting && (state != SACC_RC_WAIT);
   wire [9:0] sar_next = comp_hi ? sar : (sar & ~(10'h001 << bit_idx));

   sacc_sync u_comp_sync (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .async_in (comp_hi_async),
      .sync_out (comp_hi)
   );

   sacc_clkgen u_clkgen (
      .clk_sys           (clk_sys),
      .arst_n            (arst_n),
      .run               (tick_run),
      .conv_clock_select (conv_clock_select),
      .tick              (tick)
   );

   // Sequencer: 1 sample period, 10 bit periods, 1 finish period.
   always_comb begin
      next_state = state;
      case (state)
         SACC_IDLE:    if (start_ok) next_state = use_rc ? SACC_RC_WAIT : SACC_SAMPLE;
         SACC_RC_WAIT: if (rc_wait == 4'h1) next_state = SACC_SAMPLE;
         SACC_SAMPLE:  if (tick) next_state = SACC_BITS;
         SACC_BITS:    if (last_bit) next_state = SACC_FINISH;
         SACC_FINISH:  if (tick) next_state = SACC_IDLE;
         default:      next_state = SACC_IDLE;
      endcase
      if (abort) next_state = SACC_IDLE;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state       <= SACC_IDLE;
         module_on_q <= 1'b0;
      end else begin
         state       <= next_state;
         module_on_q <= module_on;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rc_wait <= 4'h0;
      end else if (start_ok) begin
         rc_wait <= 4'(`SACC_INSTR_CYCLES);
      end else if (rc_wait != 4'h0) begin
         rc_wait <= rc_wait - 4'h1;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         period_cnt <= 4'h0;
         bit_idx    <= 4'h9;
         sar        <= 10'h000;
      end else if (state == SACC_IDLE || state == SACC_RC_WAIT) begin
         period_cnt <= 4'h0;
         bit_idx    <= 4'h9;
         sar        <= 10'h200;
      end else if (tick) begin
         period_cnt <= period_cnt + 4'h1;
         if (state == SACC_BITS) begin
            sar <= (bit_idx == 4'h0) ? sar_next : (sar_next | (10'h001 << (bit_idx - 4'h1)));
            bit_idx <= bit_idx - 4'h1;
         end
      end
   end

   // Go bit: set by a start, cleared at completion or abort.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         go_done <= 1'b0;
      end else if (start_ok) begin
         go_done <= 1'b1;
      end else if (finish || abort) begin
         go_done <= 1'b0;
      end
   end

   // Set wins over a simultaneous software clear.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         conversion_done_flag <= 1'b0;
      end else if (finish) begin
         conversion_done_flag <= 1'b1;
      end else if (flag_clear) begin
         conversion_done_flag <= 1'b0;
      end
   end

   // Result registers load only at completion.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         result_high <= 8'h00;
         result_low  <= 8'h00;
      end else if (finish) begin
         if (result_justify) begin
            result_high <= {6'h00, sar[9:8]};
            result_low  <= sar[7:0];
         end else begin
            result_high <= sar[9:2];
            result_low  <= {sar[1:0], 6'h00};
         end
      end
   end

   // Sleep power-down latches until the module bit is cleared or sleep ends.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         powered_down <= 1'b0;
      end else if (!module_on || !sleep_mode) begin
         powered_down <= 1'b0;
      end else if (finish && use_rc && !conversion_irq_enable) begin
         powered_down <= 1'b1;
      end else if (!use_rc) begin
         powered_down <= 1'b1;
      end
   end

   // Wake and vector outputs: one-cycle events at completion.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wake_up    <= 1'b0;
         vector_isr <= 1'b0;
      end else begin
         wake_up    <= finish && wake_ok && sleep_mode;
         vector_isr <= finish && wake_ok && global_irq_enable;
      end
   end

   // Analog-side controls, all registered.
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         mux_channel  <= `SACC_CHAN_RESET;
         pref_sel     <= `SACC_PREF_RESET;
         nref_sel     <= 1'b0;
         analog_power <= 1'b0;
         sample_hold  <= 1'b0;
         trial_code   <= 10'h000;
      end else begin
         mux_channel  <= channel_select;
         pref_sel     <= positive_ref_select;
         nref_sel     <= negative_ref_select;
         analog_power <= run_ok;
         sample_hold  <= (state == SACC_BITS || state == SACC_FINISH);
         trial_code   <= sar;
      end
   end

   sequence s_start;
      start_ok && !use_rc;
   endsequence

   sequence s_done;
      finish ##1 (conversion_done_flag && !go_done);
   endsequence

   sequence s_hold_pulse;
      sample_hold ##1 !sample_hold;
   endsequence

   // Start and completion handshake
   go_start_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      start_ok |=> go_done)
      else $error("go not set after start");
   turnon_block_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (module_on && !module_on_q) |-> !start_ok)
      else $error("start on turn-on");
   done_seq_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      finish |-> s_done)
      else $error("completion steps missing");
   go_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (go_done && !finish && !abort) |=> go_done)
      else $error("go dropped early");
   result_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !finish |=> ($stable(result_high) && $stable(result_low)))
      else $error("result changed outside completion");

   // Done flag
   flag_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (finish && flag_clear) |=> conversion_done_flag)
      else $error("flag lost");
   flag_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (conversion_done_flag && !flag_clear) |=> conversion_done_flag)
      else $error("flag cleared by hardware");
   flag_rise_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      $rose(conversion_done_flag) |-> $past(finish))
      else $error("flag set without completion");

   // Clock source, RC wait, sleep and power
   rc_wait_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (start_ok && use_rc && module_on && !sleep_mode) |=> state == SACC_RC_WAIT)
      else $error("rc wait skipped");
   rc_count_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (start_ok && use_rc) |=> rc_wait == 4'(`SACC_INSTR_CYCLES))
      else $error("rc wait length wrong");
   rc_exit_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (state == SACC_RC_WAIT && rc_wait == 4'h1 && !abort) |=> state == SACC_SAMPLE)
      else $error("rc wait not left");
   wait_no_tick_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (state == SACC_RC_WAIT) |-> !tick)
      else $error("conversion clock during rc wait");
   direct_start_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      s_start |=> state == SACC_SAMPLE)
      else $error("prescaled start delayed");
   sleep_abort_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (converting && sleep_mode && !use_rc) |=> (state == SACC_IDLE && !go_done))
      else $error("non-rc sleep not aborted");
   sleep_off_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (sleep_mode && !use_rc) |=> !analog_power)
      else $error("powered in sleep without rc clock");
   rc_sleep_off_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (finish && use_rc && sleep_mode && module_on && !conversion_irq_enable) |=> powered_down)
      else $error("rc sleep conversion left powered");
   power_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !module_on |=> !analog_power)
      else $error("powered while off");
   off_idle_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      !module_on |=> state == SACC_IDLE)
      else $error("converting while off");

   // Sequencer and result layout
   conv_len_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      finish |-> period_cnt == 4'(`SACC_CONV_PERIODS - 1))
      else $error("period count wrong");
   msb_trial_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (state == SACC_SAMPLE) |-> sar == 10'h200)
      else $error("first trial not msb");
   msb_step_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (state == SACC_BITS && tick) |=> bit_idx == $past(bit_idx) - 4'h1)
      else $error("bit order wrong");
   trial_follow_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      1'b1 |=> trial_code == $past(sar))
      else $error("trial code stale");
   hold_pulse_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      finish |=> s_hold_pulse)
      else $error("hold window wrong");
   right_fmt_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (finish && result_justify) |=>
         (result_high[7:2] == 6'h00 && result_low == $past(sar[7:0])))
      else $error("right justify wrong");
   left_fmt_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (finish && !result_justify) |=>
         (result_low[5:0] == 6'h00 && result_high == $past(sar[9:2])))
      else $error("left justify wrong");

   // Analog-side selects
   mux_follow_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      1'b1 |=> mux_channel == $past(channel_select))
      else $error("channel not routed");
   pref_follow_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      1'b1 |=> pref_sel == $past(positive_ref_select))
      else $error("positive reference not routed");
   nref_follow_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      1'b1 |=> nref_sel == $past(negative_ref_select))
      else $error("negative reference not routed");

   // Wake and vector events
   wake_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (finish && wake_ok && sleep_mode) |=> wake_up)
      else $error("no wake at completion");
   wake_flag_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      wake_up |-> conversion_done_flag)
      else $error("wake without flag");
   isr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      vector_isr |-> $past(finish && wake_ok && global_irq_enable))
      else $error("vector without enables");
   inline_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
      (finish && wake_ok && !global_irq_enable) |=> !vector_isr)
      else $error("vector with global enable clear");
endmodule // sacc_top

// >>> tb/sacc_comp_model.sv
/*
 Comparator and sample-hold stand-in facing the converter control block.
 Assumes trial_code is registered by the block and vin is held per conversion.
*/
`timescale 1ns/1ps
module sacc_comp_model (
   input  wire logic       clk_sys,
   input  wire logic       analog_power,
   input  wire logic [9:0] trial_code,
   input  wire logic [9:0] vin,
   output logic            comp_hi_async
);
   logic idle_pat = 1'b0;

   // Unpowered: no verdict, so toggle rather than hold a stale level
   always @(posedge clk_sys) begin
      idle_pat <= ~idle_pat;
   end
   assign comp_hi_async = analog_power ? (vin >= trial_code) : idle_pat;
endmodule // sacc_comp_model

// >>> tb/tb_sacc_top.sv
/*
 Self-checking bench for the converter control block.
 Assumes the comparator model in tb/ and the design sources in src/.
*/
`timescale 1ns/1ps
module tb_sacc_top;
   typedef struct packed {
      logic [7:0] rh;
      logic [7:0] rl;
      logic       wk;
      logic       vc;
      logic       ck;
   } sacc_exp_t;

   logic clk_sys = 1'b0, arst_n = 1'b0, module_on = 1'b0, go_write = 1'b0;
   logic flag_clear = 1'b0, negative_ref_select = 1'b0, result_justify = 1'b0;
   logic conversion_irq_enable = 1'b0, peripheral_irq_enable = 1'b0;
   logic global_irq_enable = 1'b0, sleep_mode = 1'b0, comp_hi_async;
   logic [5:0] channel_select = 6'h00, mux_channel;
   logic [1:0] positive_ref_select = 2'h0, pref_sel;
   logic [2:0] conv_clock_select = 3'h0;
   logic [9:0] vin = 10'h000, trial_code;
   logic [7:0] result_high, result_low;
   logic       nref_sel, analog_power, sample_hold, go_done, conversion_done_flag;
   logic       wake_up, vector_isr, prev_busy = 1'b0;
   logic [31:0] seed = 32'h4f0fdc16;
   sacc_exp_t  exp_q[$];
   sacc_exp_t  seen_e;
   int         fail_count = 0, comparisons = 0, cycles = 0;
   // Ground input code is board specific; plain default
   localparam logic [5:0] GROUND_CHAN = 6'h00;

   always #4 clk_sys = ~clk_sys;

   sacc_top sacc_top_inst (.clk_sys(clk_sys), .arst_n(arst_n), .module_on(module_on),
      .go_write(go_write), .flag_clear(flag_clear), .channel_select(channel_select),
      .positive_ref_select(positive_ref_select), .negative_ref_select(negative_ref_select),
      .conv_clock_select(conv_clock_select), .result_justify(result_justify),
      .conversion_irq_enable(conversion_irq_enable),
      .peripheral_irq_enable(peripheral_irq_enable), .global_irq_enable(global_irq_enable),
      .sleep_mode(sleep_mode), .comp_hi_async(comp_hi_async), .mux_channel(mux_channel),
      .pref_sel(pref_sel), .nref_sel(nref_sel), .analog_power(analog_power),
      .sample_hold(sample_hold), .trial_code(trial_code), .go_done(go_done),
      .conversion_done_flag(conversion_done_flag), .result_high(result_high),
      .result_low(result_low), .wake_up(wake_up), .vector_isr(vector_isr));

   sacc_comp_model sacc_comp_model_inst (.clk_sys(clk_sys), .analog_power(analog_power),
      .trial_code(trial_code), .vin(vin), .comp_hi_async(comp_hi_async));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   function automatic int div_of(input logic [2:0] cs);
      case (cs)
         3'b000:  return 2;
         3'b100:  return 4;
         3'b001:  return 8;
         3'b101:  return 16;
         3'b010:  return 32;
         3'b110:  return 64;
         default: return 33;
      endcase
   endfunction

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Hang guard sized well above the longest expected run
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         summarize();
      end
   end

   // Completion watcher: busy falls with flag set
   always @(posedge clk_sys) begin
      #1;
      if (prev_busy && go_done === 1'b0 && conversion_done_flag === 1'b1) begin
         chk("pending_note", (exp_q.size() > 0), 1'b1);
         seen_e = exp_q.pop_front();
         chk("wake_up", wake_up, seen_e.wk);
         chk("vector_isr", vector_isr, seen_e.vc);
         if (seen_e.ck) begin
            chk("result_high", result_high, seen_e.rh);
            chk("result_low", result_low, seen_e.rl);
         end
      end
      prev_busy = go_done;
   end

   task automatic conv(input logic [2:0] cs, input logic sl, input logic ie,
                       input logic pe, input logic ge);
      int n;
      int d;
      sacc_exp_t e;
      @(posedge clk_sys);
      seed = xs(seed);
      d = div_of(cs);
      vin <= seed[9:0];
      result_justify <= seed[10];
      conv_clock_select <= cs;
      sleep_mode <= sl;
      conversion_irq_enable <= ie;
      peripheral_irq_enable <= pe;
      global_irq_enable <= ge;
      e.rh = seed[10] ? {6'h00, seed[9:8]} : seed[9:2];
      e.rl = seed[10] ? seed[7:0] : {seed[1:0], 6'h00};
      e.wk = sl & ie & pe;
      e.vc = ie & pe & ge;
      e.ck = (d >= 16);
      exp_q.push_back(e);
      @(posedge clk_sys);
      go_write <= 1'b1;
      @(posedge clk_sys);
      go_write <= 1'b0;
      #1;
      chk("go_done_set", go_done, 1'b1);
      n = 0;
      while (go_done === 1'b1 && n < 2000) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk("busy_length", (n >= 11 * d && n <= 13 * d + 8), 1'b1);
   endtask

   task automatic pulse_clear;
      @(posedge clk_sys);
      flag_clear <= 1'b1;
      @(posedge clk_sys);
      flag_clear <= 1'b0;
      #1;
      chk("flag_cleared", conversion_done_flag, 1'b0);
   endtask

   initial begin
      repeat (10) @(posedge clk_sys);
      arst_n <= 1'b1;
      #1;
      chk("reset_outputs", {go_done, conversion_done_flag, analog_power, result_high}, 0);
      @(posedge clk_sys);
      module_on <= 1'b1;
      go_write <= 1'b1;
      @(posedge clk_sys);
      go_write <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("go_with_turn_on", go_done, 1'b0);
      chk("analog_power_on", analog_power, 1'b1);
      @(posedge clk_sys);
      channel_select <= GROUND_CHAN;
      repeat (4) @(posedge clk_sys);
      #1;
      chk("ground_select", 16'(mux_channel), 16'(GROUND_CHAN));
      @(posedge clk_sys);
      seed = xs(seed);
      channel_select <= seed[5:0];
      positive_ref_select <= seed[7:6];
      negative_ref_select <= seed[8];
      @(posedge clk_sys);
      #1;
      chk("selects", {mux_channel, pref_sel, nref_sel}, {seed[5:0], seed[7:6], seed[8]});
      $display("test reset_and_select done");
      for (int i = 0; i < 8; i++) conv(i[2:0], 1'b0, 1'b0, 1'b0, 1'b0);
      conv(3'b010, 1'b0, 1'b1, 1'b1, 1'b1);
      chk("flag_sticky", conversion_done_flag, 1'b1);
      pulse_clear();
      $display("test clock_codes done");
      conv(3'b011, 1'b1, 1'b1, 1'b1, 1'b0);
      conv(3'b111, 1'b1, 1'b1, 1'b1, 1'b1);
      conv(3'b011, 1'b1, 1'b0, 1'b0, 1'b0);
      @(posedge clk_sys);
      #1;
      chk("sleep_power_down", analog_power, 1'b0);
      @(posedge clk_sys);
      sleep_mode <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      chk("power_back", analog_power, 1'b1);
      pulse_clear();
      $display("test sleep_wake done");
      @(posedge clk_sys);
      conv_clock_select <= 3'b110;
      go_write <= 1'b1;
      @(posedge clk_sys);
      go_write <= 1'b0;
      repeat (100) @(posedge clk_sys);
      sleep_mode <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      chk("sleep_abort", {go_done, analog_power, conversion_done_flag}, 3'b000);
      @(posedge clk_sys);
      sleep_mode <= 1'b0;
      module_on <= 1'b0;
      @(posedge clk_sys);
      go_write <= 1'b1;
      @(posedge clk_sys);
      go_write <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("off_refuses_go", {go_done, analog_power}, 2'b00);
      $display("test abort_and_off done");
      @(posedge clk_sys);
      module_on <= 1'b1;
      repeat (2) @(posedge clk_sys);
      go_write <= 1'b1;
      @(posedge clk_sys);
      go_write <= 1'b0;
      repeat (50) @(posedge clk_sys);
      arst_n <= 1'b0;
      #1;
      chk("reset_abort", {go_done, analog_power, result_high, result_low}, 0);
      chk("notes_left", 16'(exp_q.size()), 16'h0000);
      $display("test reset_abort done");
      summarize();
   end
endmodule // tb_sacc_top
